//--- rtl/ext_status_builder.v
// Extended status word builder with compact status and register port
// Operation
// - Short averaging: flag no fresh value in 10s
// - Long averaging: flag buffer below half full
// - Bit 1 follows heating switch-on criterion
// - Bit 2 follows heater energised state
// - Bit 4 flags persistent fault over one minute
// - Bits 8-11 give fill level in sixteenths
// - Bit 13 set in first telegram after restart
// - Compact status derived from extended word
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ext_status_consts.vh"

module ext_status_builder #(
	parameter [31:0] NOMEAS_CYC = `NOMEAS_CYCLES,
	parameter [31:0] STATIC_CYC = `STATIC_CYCLES
) (
	// Clock, reset, enable
	input  wire        SYS_CLK_IN,
	input  wire        RST_B_IN,
	input  wire        CE_IN,
	// Measurement side
	input  wire        MEAS_VALID_IN,
	input  wire [15:0] BUF_COUNT_IN,
	input  wire        VT_FAULT_IN,
	// Heater side
	input  wire        HEAT_CRIT_IN,
	input  wire        HEAT_ON_IN,
	// Telegram side
	input  wire        TLG_SEND_IN,
	output reg  [31:0] EXT_STATUS_OUT,
	output reg  [7:0]  COMPACT_STATUS_OUT,
	// Register port
	input  wire [7:0]  REG_ADDR_IN,
	input  wire [31:0] REG_WDATA_IN,
	input  wire        REG_WR_IN,
	input  wire        REG_RD_IN,
	output reg  [31:0] REG_RDATA_OUT,
	// Interrupt
	output reg         IRQ_OUT
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	reg  [15:0]              avg_q;
	reg  [`IRQ_WIDTH-1:0]    irq_mask_q;
	reg  [`IRQ_WIDTH-1:0]    irq_st_q;
	reg  [`IRQ_WIDTH-1:0]    irq_st_d;
	reg  [`IRQ_WIDTH-1:0]    irq_clr;
	reg  [`IRQ_WIDTH-1:0]    irq_ev;
	reg                      first_q;
	reg  [31:0]              ext_d;
	reg  [7:0]               cmp_d;
	reg  [31:0]              rdata_d;
	reg  [19:0]              thr;
	reg  [3:0]               fill_code;
	reg                      gen_fault;
	integer                  i;

	wire                     nomeas_short;
	wire                     nomeas_long;
	wire                     vt_long;
	wire                     static_fault;
	wire                     short_avg;
	wire                     below_half;
	wire [19:0]              count_x16;
	wire                     wr_avg;
	wire                     wr_mask;
	wire                     wr_clr;

	////////////////////////////////////////////////////////////////////////
	// Persistence timers

	// Restarts on every fresh value, so it measures the gap between two
	persist_timer #(
		.LIMIT (NOMEAS_CYC)
	) u_nomeas_short (
		.clk_in   (SYS_CLK_IN),
		.rst_b_in (RST_B_IN),
		.ce_in    (CE_IN),
		.cond_in  (1'b1),
		.clear_in (MEAS_VALID_IN),
		.flag_out (nomeas_short)
	);

	persist_timer #(
		.LIMIT (STATIC_CYC)
	) u_nomeas_long (
		.clk_in   (SYS_CLK_IN),
		.rst_b_in (RST_B_IN),
		.ce_in    (CE_IN),
		.cond_in  (1'b1),
		.clear_in (MEAS_VALID_IN),
		.flag_out (nomeas_long)
	);

	persist_timer #(
		.LIMIT (STATIC_CYC)
	) u_vt_long (
		.clk_in   (SYS_CLK_IN),
		.rst_b_in (RST_B_IN),
		.ce_in    (CE_IN),
		.cond_in  (VT_FAULT_IN),
		.clear_in (1'b0),
		.flag_out (vt_long)
	);

	assign static_fault = nomeas_long | vt_long;

	////////////////////////////////////////////////////////////////////////
	// Buffer fill evaluation

	// One value per second is expected, so the averaging time in seconds
	// is also the number of values a full buffer holds
	assign short_avg  = (avg_q < `AVG_SPLIT_S);
	assign below_half = ({BUF_COUNT_IN, 1'b0} < {1'b0, avg_q});
	assign count_x16  = {BUF_COUNT_IN, 4'h0};

	always @* begin
		if (short_avg)
			gen_fault = nomeas_short;
		else
			gen_fault = below_half;
	end

	// Largest n with fill above n/16; a ripple of adds avoids a divider
	always @* begin
		thr       = 20'h00000;
		fill_code = 4'h0;
		for (i = 1; i < 16; i = i + 1) begin
			thr = thr + {4'h0, avg_q};
			if (count_x16 > thr)
				fill_code = i[3:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status word assembly

	always @* begin
		ext_d = 32'h00000000;
		ext_d[`EXT_GEN_BIT]    = gen_fault;
		ext_d[`EXT_CRIT_BIT]   = HEAT_CRIT_IN;
		ext_d[`EXT_HEAT_BIT]   = HEAT_ON_IN;
		ext_d[`EXT_STATIC_BIT] = static_fault;
		ext_d[`EXT_FILL_MSB:`EXT_FILL_LSB] = fill_code;
		// Dropped in the send cycle, so the next telegram already lacks it
		ext_d[`EXT_RESTART_BIT] = first_q & ~TLG_SEND_IN;
	end

	// Compact form keeps only the top three bits of the fill code
	always @* begin
		cmp_d = 8'h00;
		cmp_d[`CMP_GEN_BIT] = ext_d[`EXT_GEN_BIT];
		cmp_d[`CMP_FILL_MSB:`CMP_FILL_LSB] =
			ext_d[`EXT_FILL_MSB:`EXT_FILL_LSB+1];
		cmp_d[`CMP_STATIC_BIT] = ext_d[`EXT_STATIC_BIT];
		cmp_d[`CMP_CRIT_BIT]   = ext_d[`EXT_CRIT_BIT];
		cmp_d[`CMP_HEAT_BIT]   = ext_d[`EXT_HEAT_BIT];
	end

	// Restart flag: high from reset until the first telegram is sent
	always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			first_q <= 1'b1;
		end else if (CE_IN) begin
			if (TLG_SEND_IN)
				first_q <= 1'b0;
		end
	end

	always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			EXT_STATUS_OUT     <= `EXT_STATUS_RST;
			COMPACT_STATUS_OUT <= `COMPACT_RST;
		end else if (CE_IN) begin
			EXT_STATUS_OUT     <= ext_d;
			COMPACT_STATUS_OUT <= cmp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port

	assign wr_avg  = REG_WR_IN & (REG_ADDR_IN == `ADDR_AVG_TIME);
	assign wr_mask = REG_WR_IN & (REG_ADDR_IN == `ADDR_IRQ_MASK);
	assign wr_clr  = REG_WR_IN & (REG_ADDR_IN == `ADDR_IRQ_STATUS);

	always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			avg_q      <= `AVG_TIME_RST;
			irq_mask_q <= `IRQ_MASK_RST;
		end else if (CE_IN) begin
			if (wr_avg)
				avg_q <= REG_WDATA_IN[15:0];
			if (wr_mask)
				irq_mask_q <= REG_WDATA_IN[`IRQ_WIDTH-1:0];
		end
	end

	// Unmapped reads return zero
	always @* begin
		case (REG_ADDR_IN)
			`ADDR_EXT_STATUS: rdata_d = EXT_STATUS_OUT;
			`ADDR_COMPACT:    rdata_d = {24'h000000, COMPACT_STATUS_OUT};
			`ADDR_AVG_TIME:   rdata_d = {16'h0000, avg_q};
			`ADDR_IRQ_STATUS: rdata_d = {29'h00000000, irq_st_q};
			`ADDR_IRQ_MASK:   rdata_d = {29'h00000000, irq_mask_q};
			default:          rdata_d = 32'h00000000;
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			REG_RDATA_OUT <= 32'h00000000;
		end else if (CE_IN) begin
			if (REG_RD_IN)
				REG_RDATA_OUT <= rdata_d;
			else
				REG_RDATA_OUT <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts

	always @* begin
		irq_ev = {`IRQ_WIDTH{1'b0}};
		irq_ev[`IRQ_GEN_BIT] = ext_d[`EXT_GEN_BIT] &
			~EXT_STATUS_OUT[`EXT_GEN_BIT];
		irq_ev[`IRQ_STATIC_BIT] = ext_d[`EXT_STATIC_BIT] &
			~EXT_STATUS_OUT[`EXT_STATIC_BIT];
		irq_ev[`IRQ_FIRST_BIT] = TLG_SEND_IN & first_q;
	end

	// A new event in the clearing cycle survives the clear
	always @* begin
		irq_clr = {`IRQ_WIDTH{1'b0}};
		if (wr_clr)
			irq_clr = REG_WDATA_IN[`IRQ_WIDTH-1:0];
		irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;
	end

	always @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			irq_st_q <= `IRQ_STATUS_RST;
			IRQ_OUT  <= 1'b0;
		end else if (CE_IN) begin
			irq_st_q <= irq_st_d;
			IRQ_OUT  <= |(irq_st_d & irq_mask_q);
		end
	end

endmodule // ext_status_builder

`default_nettype wire

//--- rtl/ext_status_consts.vh
// Constants for the extended status word builder
`ifndef EXT_STATUS_CONSTS_VH
`define EXT_STATUS_CONSTS_VH

// Register offsets (byte addresses)
`define ADDR_EXT_STATUS   8'h00
`define ADDR_COMPACT      8'h04
`define ADDR_AVG_TIME     8'h08
`define ADDR_IRQ_STATUS   8'h0C
`define ADDR_IRQ_MASK     8'h10

// Extended status word fields
`define EXT_GEN_BIT       0
`define EXT_CRIT_BIT      1
`define EXT_HEAT_BIT      2
`define EXT_STATIC_BIT    4
`define EXT_FILL_LSB      8
`define EXT_FILL_MSB      11
`define EXT_RESTART_BIT   13

// Compact status fields
`define CMP_GEN_BIT       0
`define CMP_FILL_LSB      1
`define CMP_FILL_MSB      3
`define CMP_STATIC_BIT    5
`define CMP_CRIT_BIT      6
`define CMP_HEAT_BIT      7

// Interrupt status fields
`define IRQ_GEN_BIT       0
`define IRQ_STATIC_BIT    1
`define IRQ_FIRST_BIT     2
`define IRQ_WIDTH         3

// Reset values
`define AVG_TIME_RST      16'h0001
`define IRQ_MASK_RST      3'h0
`define IRQ_STATUS_RST    3'h0
// Restart flag already shows in reset, so an early telegram carries it
`define EXT_STATUS_RST    32'h00002000
`define COMPACT_RST       8'h00

// Timing
`define CLK_HZ            32'd50000000
`define NOMEAS_TIME_S     32'd10
`define STATIC_TIME_S     32'd60
`define NOMEAS_CYCLES     (`NOMEAS_TIME_S * `CLK_HZ)
`define STATIC_CYCLES     (`STATIC_TIME_S * `CLK_HZ)
`define AVG_SPLIT_S       16'h000A

`endif

//--- rtl/persist_timer.v
// Persistence timer: flags a condition held for a given number of cycles
`timescale 1ns/1ps
`default_nettype none

module persist_timer #(
	parameter [31:0] LIMIT = 32'd10
) (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_b_in,
	input  wire        ce_in,
	// Condition
	input  wire        cond_in,
	input  wire        clear_in,
	// Result
	output reg         flag_out
);

	reg  [31:0] cnt_q;
	wire        run;

	assign run = cond_in & ~clear_in;

	// Counter saturates so a long fault never wraps back to clean
	always @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q    <= 32'h00000000;
			flag_out <= 1'b0;
		end else if (ce_in) begin
			if (!run) begin
				cnt_q    <= 32'h00000000;
				flag_out <= 1'b0;
			end else begin
				if (cnt_q != LIMIT)
					cnt_q <= cnt_q + 32'h00000001;
				flag_out <= (cnt_q == LIMIT);
			end
		end
	end

endmodule // persist_timer

`default_nettype wire

//--- tb/ext_status_builder_sva.sv
// Assertions for the extended status word builder
`timescale 1ns/1ps
`default_nettype none
module ext_status_sva (
	// Clock and inputs
	input wire logic        SYS_CLK_IN,
	input wire logic        RST_B_IN,
	input wire logic        CE_IN,
	input wire logic        MEAS_VALID_IN,
	input wire logic        VT_FAULT_IN,
	input wire logic        HEAT_CRIT_IN,
	input wire logic        HEAT_ON_IN,
	input wire logic        TLG_SEND_IN,
	input wire logic        REG_RD_IN,
	// Outputs
	input wire logic [31:0] EXT_STATUS_OUT,
	input wire logic [7:0]  COMPACT_STATUS_OUT,
	input wire logic [31:0] REG_RDATA_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	////////////////////////////////////////////////////////////////////////
	a_rsvd_zero: assert property (
		(EXT_STATUS_OUT & 32'hFFFFD0E8) == 32'h00000000)
		else $error("reserved bit set");
	// Reset guard: the release edge still sees the flops held
	a_crit_follow: assert property (
		CE_IN && RST_B_IN |=> EXT_STATUS_OUT[1] == $past(HEAT_CRIT_IN))
		else $error("heating criterion bit wrong");
	a_heat_follow: assert property (
		CE_IN && RST_B_IN |=> EXT_STATUS_OUT[2] == $past(HEAT_ON_IN))
		else $error("heating on bit wrong");
	a_restart_clr: assert property (
		CE_IN && TLG_SEND_IN |=> !EXT_STATUS_OUT[13])
		else $error("restart flag kept after telegram");
	a_restart_hold: assert property (
		$past(RST_B_IN) && !EXT_STATUS_OUT[13] |=> !EXT_STATUS_OUT[13])
		else $error("restart flag set again");
	a_compact_map: assert property (
		COMPACT_STATUS_OUT == {EXT_STATUS_OUT[2:1], EXT_STATUS_OUT[4], 1'b0,
		EXT_STATUS_OUT[11:9], EXT_STATUS_OUT[0]})
		else $error("compact status inconsistent");
	a_static_clr: assert property (
		CE_IN && MEAS_VALID_IN && !VT_FAULT_IN |-> ##[1:4] !EXT_STATUS_OUT[4])
		else $error("static malfunction kept");
	a_rdata_idle: assert property (
		!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h00000000)
		else $error("read data outside read cycle");
	c_first_tlg: cover property (TLG_SEND_IN && EXT_STATUS_OUT[13]);
	c_gen_malf: cover property (EXT_STATUS_OUT[0]);
	c_static: cover property (EXT_STATUS_OUT[4]);
endmodule // ext_status_sva
bind ext_status_builder ext_status_sva u_sva (
	.SYS_CLK_IN(SYS_CLK_IN), .RST_B_IN(RST_B_IN), .CE_IN(CE_IN),
	.MEAS_VALID_IN(MEAS_VALID_IN), .VT_FAULT_IN(VT_FAULT_IN),
	.HEAT_CRIT_IN(HEAT_CRIT_IN), .HEAT_ON_IN(HEAT_ON_IN),
	.TLG_SEND_IN(TLG_SEND_IN), .REG_RD_IN(REG_RD_IN),
	.EXT_STATUS_OUT(EXT_STATUS_OUT), .COMPACT_STATUS_OUT(COMPACT_STATUS_OUT),
	.REG_RDATA_OUT(REG_RDATA_OUT));
`default_nettype wire

//--- tb/telegram_host.sv
// Host model that requests telegrams and captures the status word
`timescale 1ns/1ps
`default_nettype none
module telegram_host (
	// Clock and request
	input  wire logic        clk_in,
	input  wire logic        req_in,
	// Telegram side
	input  wire logic [31:0] word_in,
	output var  logic        send_out,
	output var  logic [31:0] word_out
);
	initial send_out = 1'b0;
	// Capture in the send cycle itself; one later misses the restart flag
	always @(posedge clk_in) begin
		send_out <= req_in;
		if (send_out) begin
			word_out <= word_in;
		end
	end
endmodule // telegram_host
`default_nettype wire

//--- tb/test_ext_status_builder.sv
// Self-checking bench for the extended status word builder
`timescale 1ns/1ps
`default_nettype none
module test_ext_status_builder;
	logic        clk, rst_b, meas, meas_on, vt, crit, heat, req, wr, rd;
	logic        tlg, irq, ce;
	logic [1:0]  ph = 2'h0;
	logic [3:0]  f;
	logic [7:0]  addr, cmp;
	logic [15:0] cnt;
	logic [31:0] wdata, rdata, ext, word;
	int          error_cnt, tests_run, n;
	////////////////////////////////////////////////////////////////////////
	ext_status_builder #(.NOMEAS_CYC(32'd20), .STATIC_CYC(32'd50)) u_dut (
		.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .CE_IN(ce),
		.MEAS_VALID_IN(meas), .BUF_COUNT_IN(cnt), .VT_FAULT_IN(vt),
		.HEAT_CRIT_IN(crit), .HEAT_ON_IN(heat), .TLG_SEND_IN(tlg),
		.EXT_STATUS_OUT(ext), .COMPACT_STATUS_OUT(cmp), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdata), .IRQ_OUT(irq));
	telegram_host u_host (.clk_in(clk), .req_in(req), .word_in(ext),
		.send_out(tlg), .word_out(word));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		ph <= ph + 2'h1;
		meas <= meas_on && ph == 2'h3;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
		@(posedge clk) wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk) begin addr <= a; rd <= 1'b1; end
		@(posedge clk) rd <= 1'b0;
		@(negedge clk) chk(rdata, exp);
	endtask
	task automatic send(input logic [31:0] exp);
		@(posedge clk) req <= 1'b1;
		@(posedge clk) req <= 1'b0;
		@(posedge clk);
		@(negedge clk) chk(word, exp);
	endtask
	task automatic tally_and_finish;
		if (error_cnt == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Whole run needs well under 1000 cycles
	initial begin
		#200000;
		error_cnt++;
		tally_and_finish;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_b, vt, heat, req, wr, rd} = 6'h00;
		{meas_on, crit, ce} = 3'h7;
		cnt = 16'h0000;
		addr = 8'h00;
		wdata = 32'h00000000;
		error_cnt = 0;
		tests_run = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		send(32'h00002002);
		send(32'h00000002);
		for (n = 0; n < 4; n++) begin
			@(posedge clk) {heat, crit} <= n[1:0];
			repeat (3) @(negedge clk);
			chk(ext, {29'h0, n[1:0], 1'b0});
		end
		@(posedge clk) ce <= 1'b0;
		crit <= 1'b0;
		repeat (3) @(negedge clk);
		chk(ext, 32'h00000006);
		@(posedge clk) ce <= 1'b1;
		repeat (2) @(negedge clk);
		chk(ext, 32'h00000004);
		@(posedge clk) crit <= 1'b1;
		rd_reg(8'h00, 32'h00000006);
		rd_reg(8'h04, 32'h000000C0);
		rd_reg(8'h20, 32'h00000000);
		rd_reg(8'h0C, 32'h00000004);
		wr_reg(8'h08, 32'h00000010);
		rd_reg(8'h08, 32'h00000010);
		for (n = 0; n < 18; n++) begin
			@(posedge clk) cnt <= n[15:0];
			repeat (3) @(negedge clk);
			f = (n == 0) ? 4'h0 : (n >= 16) ? 4'hF : 4'(n - 1);
			chk(ext, {20'h0, f, 5'h0, 2'h3, n < 8});
			chk({24'h0, cmp}, {24'h0, 4'hC, f[3:1], n < 8});
		end
		wr_reg(8'h08, 32'h00000001);
		wr_reg(8'h10, 32'h00000001);
		wr_reg(8'h0C, 32'h00000007);
		@(posedge clk) meas_on <= 1'b0;
		repeat (12) @(negedge clk);
		chk({30'h0, ext[0], irq}, 32'h00000000);
		repeat (18) @(negedge clk);
		chk({30'h0, ext[0], irq}, 32'h00000003);
		chk({31'h0, ext[4]}, 32'h00000000);
		rd_reg(8'h0C, 32'h00000001);
		for (n = 0; n < 3; n++) begin
			wr_reg(n == 2 ? 8'h0C : 8'h10, {31'h0, n != 0});
			repeat (2) @(negedge clk);
			chk({31'h0, irq}, {31'h0, n == 1});
		end
		rd_reg(8'h10, 32'h00000001);
		repeat (60) @(negedge clk);
		chk({31'h0, ext[4]}, 32'h00000001);
		rd_reg(8'h0C, 32'h00000002);
		@(posedge clk) meas_on <= 1'b1;
		repeat (8) @(negedge clk);
		chk(ext & 32'h00000011, 32'h00000000);
		@(posedge clk) vt <= 1'b1;
		repeat (70) @(negedge clk);
		chk({31'h0, ext[4]}, 32'h00000001);
		tally_and_finish;
	end
endmodule // test_ext_status_builder
`default_nettype wire
